// ===== etpm_pkg.sv
// Package for the event timer / pulse measurement channel.
// Assumes a 32-bit AHB-Lite register bus with word-aligned registers.
package etpm_pkg;
	// Register byte offsets.
	localparam logic [7:0] OFS_TIMER = 8'h00;
	localparam logic [7:0] OFS_MODE = 8'h04;
	localparam logic [7:0] OFS_START = 8'h08;
	localparam logic [7:0] OFS_PORT = 8'h0C;
	// Mode register fields.
	localparam int MODE_LSB = 0;
	localparam int CSRC_LSB = 2;
	localparam int EDGE_LSB = 4;
	localparam int SRCSEL_BIT = 6;
	localparam int MEASW_BIT = 7;
	localparam int OVF_BIT = 8;
	// Status/port register fields.
	localparam int PIN_BIT = 0;
	// Reset values.
	localparam logic [15:0] TIMER_RST = 16'h0000;
	localparam logic [7:0] MODE_RST = 8'h00;
	// Prescaler division terminal counts.
	localparam logic [4:0] DIV8_LAST = 5'h07;
	localparam logic [4:0] DIV32_LAST = 5'h1F;
	// HTRANS bit set for active transfers (NONSEQ and SEQ).
	localparam int HTRANS_ACT_BIT = 1;
	typedef enum logic [1:0] {MODE_TIMER, MODE_EVENT, MODE_MEAS, MODE_RSVD} etpm_mode_e;
	typedef enum logic [1:0] {CS_DIV1, CS_DIV8, CS_DIV32, CS_SUB32} etpm_csrc_e;
	typedef enum logic [1:0] {EDGE_RISE, EDGE_FALL, EDGE_BOTH, EDGE_BOTH2} etpm_edge_e;
endpackage

// ===== etpm_timer.sv
// One 16-bit timer channel: interval timer, event counter, pulse measurement.
// Assumes one AHB-Lite master, a sub-clock tick and another timer's
// overflow pulse on the hclk domain, and an asynchronous measured pin.
`timescale 1ns/1ps
`default_nettype none
module etpm_timer (
	// Clock, reset, enable.
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic clk_en,
	// AHB-Lite slave.
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Count sources.
	input wire logic subclock_tick,
	input wire logic other_overflow,
	input wire logic channel_input_pin,
	// Interrupt request to the controller.
	output logic irq_req
);
	// ***************************************************
	// Pin synchroniser and edge detection
	// ***************************************************
	logic pin_s1, pin_s2, pin_d;
	logic next_pin_s1, next_pin_s2, next_pin_d;
	// Two flops guard against metastability; only pin_s2 and its delayed copy pin_d feed logic.
	always_comb begin
		next_pin_s1 = channel_input_pin;
		next_pin_s2 = pin_s1;
		next_pin_d = pin_s2;
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pin_s1 <= 1'b0;
			pin_s2 <= 1'b0;
			pin_d <= 1'b0;
		end else if (clk_en) begin
			pin_s1 <= next_pin_s1;
			pin_s2 <= next_pin_s2;
			pin_d <= next_pin_d;
		end
	end
	wire logic rise = pin_s2 & ~pin_d;
	wire logic fall = ~pin_s2 & pin_d;

	// ***************************************************
	// Register state
	// ***************************************************
	logic [15:0] counter, reload;
	logic [7:0] mode_reg;
	logic run, ovf, first_done, irq_q;
	logic [4:0] pre8, pre32;
	logic [4:0] next_pre8, next_pre32;
	logic [4:0] sub32, next_sub32;
	logic [15:0] next_counter, next_reload;
	logic [7:0] next_mode_reg;
	logic next_run, next_ovf, next_first_done, next_irq;
	// Bus data phase capture.
	logic dp_wr, dp_rd;
	logic [7:0] dp_addr;
	logic next_dp_wr, next_dp_rd;
	logic [7:0] next_dp_addr;
	logic [31:0] next_hrdata;

	etpm_pkg::etpm_mode_e mode;
	assign mode = etpm_pkg::etpm_mode_e'(mode_reg[etpm_pkg::MODE_LSB +: 2]);
	wire logic [1:0] csrc = mode_reg[etpm_pkg::CSRC_LSB +: 2];
	wire logic [1:0] esel = mode_reg[etpm_pkg::EDGE_LSB +: 2];

	// Select a clock tick from the four prescaled sources.
	function automatic logic tick_sel(input logic [1:0] cs, input logic t8, input logic t32,
		input logic sub);
		unique case (etpm_pkg::etpm_csrc_e'(cs))
			etpm_pkg::CS_DIV1: tick_sel = 1'b1;
			etpm_pkg::CS_DIV8: tick_sel = t8;
			etpm_pkg::CS_DIV32: tick_sel = t32;
			etpm_pkg::CS_SUB32: tick_sel = sub;
		endcase
	endfunction

	// ***************************************************
	// Count logic
	// ***************************************************
	logic int_tick, ev_tick, valid_edge, down_mode, wr_timer, wr_mode, wr_start;
	always_comb begin
		next_pre8 = (pre8 == etpm_pkg::DIV8_LAST) ? 5'h00 : pre8 + 5'h01;
		next_pre32 = pre32 + 5'h01;
		// The sub-clock has its own divide-by-32 so its rate does not hang on the hclk phase.
		next_sub32 = subclock_tick ? sub32 + 5'h01 : sub32;
		int_tick = tick_sel(csrc, pre8 == etpm_pkg::DIV8_LAST, pre32 == etpm_pkg::DIV32_LAST,
			subclock_tick && sub32 == etpm_pkg::DIV32_LAST);
		unique case (etpm_pkg::etpm_edge_e'(esel))
			etpm_pkg::EDGE_RISE: ev_tick = rise;
			etpm_pkg::EDGE_FALL: ev_tick = fall;
			default: ev_tick = rise | fall;
		endcase
		if (mode_reg[etpm_pkg::SRCSEL_BIT]) begin
			ev_tick = other_overflow;
		end
		// Width measurement captures on both edges, period on rising only.
		valid_edge = mode_reg[etpm_pkg::MEASW_BIT] ? (rise | fall) : rise;
		down_mode = (mode == etpm_pkg::MODE_TIMER) || (mode == etpm_pkg::MODE_EVENT);
		wr_timer = dp_wr && dp_addr == etpm_pkg::OFS_TIMER;
		wr_mode = dp_wr && dp_addr == etpm_pkg::OFS_MODE;
		wr_start = dp_wr && dp_addr == etpm_pkg::OFS_START;

		next_counter = counter;
		next_reload = reload;
		next_ovf = ovf;
		next_first_done = first_done;
		next_irq = 1'b0;
		next_mode_reg = wr_mode ? hwdata[7:0] : mode_reg;
		next_run = wr_start ? hwdata[0] : run;
		if (wr_mode && run) begin
			next_ovf = 1'b0;
		end
		if (wr_start && hwdata[0] && !run) begin
			next_first_done = 1'b0;
		end
		if (run) begin
			if (down_mode && ((mode == etpm_pkg::MODE_TIMER) ? int_tick : ev_tick)) begin
				if (counter == 16'h0000) begin
					next_counter = reload;
					next_irq = 1'b1;
				end else begin
					next_counter = counter - 16'h0001;
				end
			end else if (mode == etpm_pkg::MODE_MEAS) begin
				if (valid_edge) begin
					next_reload = counter;
					next_counter = 16'h0000;
					next_first_done = 1'b1;
					next_irq = first_done;
				end else if (int_tick) begin
					next_counter = counter + 16'h0001;
					if (counter == 16'hFFFF) begin
						next_ovf = 1'b1;
						next_irq = 1'b1;
					end
				end
			end
		end
		// Timer writes reach the registers only in the down-counting modes; in measurement
		// mode a write would corrupt the last capture, so it is dropped.
		if (wr_timer && down_mode) begin
			next_reload = hwdata[15:0];
			if (!run) begin
				next_counter = hwdata[15:0];
			end
		end
	end

	// ***************************************************
	// AHB-Lite slave: zero wait states, always OKAY
	// ***************************************************
	always_comb begin
		next_dp_wr = 1'b0;
		next_dp_rd = 1'b0;
		next_dp_addr = dp_addr;
		if (hsel && hready && htrans[etpm_pkg::HTRANS_ACT_BIT]) begin
			next_dp_wr = hwrite;
			next_dp_rd = !hwrite;
			next_dp_addr = haddr;
		end
		next_hrdata = 32'h0000_0000;
		if (hsel && hready && htrans[etpm_pkg::HTRANS_ACT_BIT] && !hwrite) begin
			unique case (haddr)
				// Measurement returns last capture; undefined before second edge.
				etpm_pkg::OFS_TIMER: next_hrdata = {16'h0000, down_mode ? counter : reload};
				etpm_pkg::OFS_MODE: next_hrdata = {23'h000000, ovf, mode_reg};
				etpm_pkg::OFS_START: next_hrdata = {31'h00000000, run};
				// Pin level is readable as a port in every mode.
				etpm_pkg::OFS_PORT: next_hrdata = {31'h00000000, pin_s2};
				default: next_hrdata = 32'h0000_0000;
			endcase
		end
	end

	// Registers; hsize is accepted but all accesses are treated as whole words.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			counter <= etpm_pkg::TIMER_RST;
			reload <= etpm_pkg::TIMER_RST;
			mode_reg <= etpm_pkg::MODE_RST;
			run <= 1'b0;
			ovf <= 1'b0;
			first_done <= 1'b0;
			irq_q <= 1'b0;
			pre8 <= 5'h00;
			pre32 <= 5'h00;
			sub32 <= 5'h00;
			dp_wr <= 1'b0;
			dp_rd <= 1'b0;
			dp_addr <= 8'h00;
			hrdata <= 32'h0000_0000;
		end else if (clk_en) begin
			counter <= next_counter;
			reload <= next_reload;
			mode_reg <= next_mode_reg;
			run <= next_run;
			ovf <= next_ovf;
			first_done <= next_first_done;
			irq_q <= next_irq;
			pre8 <= next_pre8;
			pre32 <= next_pre32;
			sub32 <= next_sub32;
			dp_wr <= next_dp_wr;
			dp_rd <= next_dp_rd;
			dp_addr <= next_dp_addr;
			hrdata <= next_hrdata;
		end
	end
	assign irq_req = irq_q;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	// ***************************************************
	// Assertions
	// ***************************************************
	property p_stop_hold;
		@(posedge hclk) disable iff (!hresetn)
		(!run && !wr_timer && clk_en) |=> $stable(counter);
	endproperty
	a_stop_hold: assert property (p_stop_hold) else $error("counter moved while stopped");
	property p_underflow;
		@(posedge hclk) disable iff (!hresetn)
		(clk_en && run && down_mode && counter == 16'h0000 && !wr_timer &&
			(mode == etpm_pkg::MODE_TIMER ? int_tick : ev_tick)) |=> (irq_req && counter == $past(reload));
	endproperty
	a_underflow: assert property (p_underflow) else $error("no reload on underflow");
	property p_wr_stop;
		@(posedge hclk) disable iff (!hresetn)
		(clk_en && wr_timer && down_mode && !run) |=> (counter == reload);
	endproperty
	a_wr_stop: assert property (p_wr_stop) else $error("stopped write not loaded");
	property p_meas_wr;
		@(posedge hclk) disable iff (!hresetn)
		(clk_en && wr_timer && mode == etpm_pkg::MODE_MEAS && run && !valid_edge) |=> $stable(reload);
	endproperty
	a_meas_wr: assert property (p_meas_wr) else $error("measurement write took effect");
	property p_capture;
		@(posedge hclk) disable iff (!hresetn)
		(clk_en && run && mode == etpm_pkg::MODE_MEAS && valid_edge) |=>
			(counter == 16'h0000 && reload == $past(counter) && irq_req == $past(first_done));
	endproperty
	a_capture: assert property (p_capture) else $error("bad capture");
	property p_ovf;
		@(posedge hclk) disable iff (!hresetn)
		(clk_en && run && mode == etpm_pkg::MODE_MEAS && !valid_edge && int_tick &&
			counter == 16'hFFFF && !wr_mode) |=> (ovf && irq_req);
	endproperty
	a_ovf: assert property (p_ovf) else $error("overflow missed");
	property p_ovf_clr;
		@(posedge hclk) disable iff (!hresetn)
		(clk_en && wr_mode && run && !(int_tick && counter == 16'hFFFF)) |=> !ovf;
	endproperty
	a_ovf_clr: assert property (p_ovf_clr) else $error("overflow not cleared");
	property p_first;
		@(posedge hclk) disable iff (!hresetn)
		(clk_en && wr_start && hwdata[0] && !run) |=> (!first_done && !irq_req);
	endproperty
	a_first: assert property (p_first) else $error("first edge interrupted");
	property p_wr_run;
		@(posedge hclk) disable iff (!hresetn)
		(clk_en && wr_timer && down_mode && run) |=> (reload == $past(hwdata[15:0]));
	endproperty
	a_wr_run: assert property (p_wr_run) else $error("running write missed reload");
	property p_port;
		@(posedge hclk) disable iff (!hresetn)
		(clk_en && hsel && hready && htrans[etpm_pkg::HTRANS_ACT_BIT] && !hwrite &&
			haddr == etpm_pkg::OFS_PORT) |=> (hrdata == {31'h00000000, $past(pin_s2)});
	endproperty
	a_port: assert property (p_port) else $error("port read wrong");
	property p_meas_rd;
		@(posedge hclk) disable iff (!hresetn)
		(clk_en && hsel && hready && htrans[etpm_pkg::HTRANS_ACT_BIT] && !hwrite &&
			haddr == etpm_pkg::OFS_TIMER && mode == etpm_pkg::MODE_MEAS) |=>
			(hrdata[15:0] == $past(reload));
	endproperty
	a_meas_rd: assert property (p_meas_rd) else $error("measurement read not capture");
	property p_rd_idle;
		@(posedge hclk) disable iff (!hresetn)
		!dp_rd |-> (hrdata == 32'h0000_0000);
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside data phase");
endmodule
`default_nettype wire

// ===== etpm_pin_src.sv
// Model of the signal source wired to the channel input pin.
// Assumes the bench calls its task just after a rising hclk edge.
`timescale 1ns/1ps
`default_nettype none
module etpm_pin_src (
	// Clock and pin.
	input wire logic hclk,
	output logic pin
);
	// ****
	// Pulse source
	// ****
	// The pin rests low between bursts, so a mode change sees no stray edge.
	initial pin = 1'b0;
	// Sets a steady pin level.
	task automatic level(input logic v);
		pin <= v;
	endtask
	// Sends n pulses of hi cycles high and lo cycles low.
	task automatic pulses(input int n, input int hi, input int lo);
		repeat (n) begin
			pin <= 1'b1;
			repeat (hi) @(posedge hclk);
			pin <= 1'b0;
			repeat (lo) @(posedge hclk);
		end
	endtask
endmodule
`default_nettype wire

// ===== event_timer_pulse_measure_tb_top.sv
// Self-checking bench for the timer channel.
// Assumes etpm_timer with a zero-wait AHB-Lite slave and the pin source model.
`timescale 1ns/1ps
`default_nettype none
module event_timer_pulse_measure_tb_top;
	// ****
	// Stimulus and design
	// ****
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [7:0] haddr = 8'h00;
	logic hwrite = 1'b0;
	logic oth = 1'b0;
	logic sub = 1'b0;
	logic ce = 1'b1;
	logic [31:0] hwdata = 32'h00000000;
	logic [31:0] hrdata, rd, a;
	logic hreadyout, hresp, irq_req, pin;
	int mismatches = 0, samples_checked = 0, irqs = 0, cyc = 0, last = 0, gap = 0, b;
	// Clock of 8 ns period.
	always #4 hclk = ~hclk;
	etpm_pin_src src_u (.hclk(hclk), .pin(pin));
	etpm_timer dut_u (.hclk(hclk), .hresetn(hresetn), .clk_en(ce), .hsel(1'b1),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout),
		.hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.subclock_tick(sub), .other_overflow(oth), .channel_input_pin(pin), .irq_req(irq_req));
	// Sub-clock tick on every other edge, so its divide-by-32 spans 64 hclk cycles.
	always @(posedge hclk) sub <= ~sub;
	// Counts interrupt pulses and keeps the spacing of the last two.
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		if (irq_req === 1'b1) begin
			irqs <= irqs + 1;
			gap <= cyc - last;
			last <= cyc;
		end
	end
	// One single transfer; read data is taken at the data phase edge.
	task automatic xfer(input logic w, input logic [7:0] ad, input logic [31:0] d);
		htrans <= 2'h2;
		haddr <= ad;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	// Range compare; an unknown never counts as inside.
	task automatic chk(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
		samples_checked++;
		if ((got >= lo && got <= hi) !== 1'b1) begin
			mismatches++;
			$display("Error at %0t: got %0h, expected %0h to %0h", $time, got, lo, hi);
		end
	endtask
	// Pulses the other timer's overflow input n times, one cycle high each.
	task automatic opulse(input int n);
		repeat (n) begin
			oth <= 1'b1;
			@(posedge hclk);
			oth <= 1'b0;
			@(posedge hclk);
		end
	endtask
	// Waits for n more interrupt pulses.
	task automatic wirq(input int n);
		int t;
		t = irqs + n;
		while (irqs < t) @(posedge hclk);
	endtask
	task automatic test_done;
		$display("checks %0d, mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// ****
	// Tests
	// ****
	initial begin
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		xfer(1'b0, 8'h00, 32'h0); chk(rd, 32'h0, 32'h0);
		xfer(1'b0, 8'h04, 32'h0); chk(rd, 32'h0, 32'h0);
		// Interval timer on every count source, programmed value 3.
		for (int c = 0; c < 4; c++) begin
			xfer(1'b1, 8'h08, 32'h0);
			xfer(1'b1, 8'h04, 32'(c << 2));
			xfer(1'b1, 8'h00, 32'h3);
			xfer(1'b0, 8'h00, 32'h0); chk(rd, 32'h3, 32'h3);
			xfer(1'b1, 8'h08, 32'h1);
			wirq(2);
			b = (c == 0) ? 4 : (c == 1) ? 32 : (c == 2) ? 128 : 256;
			chk(32'(gap), 32'(b), 32'(b));
		end
		// Still on the sub-clock: a running write only reaches the reload.
		xfer(1'b1, 8'h00, 32'h9);
		// Three pulses, so the last gap is a full reload of 9 even if one was pending.
		wirq(3); chk(32'(gap), 32'd640, 32'd640);
		xfer(1'b0, 8'h00, 32'h0);
		a = rd;
		repeat (70) @(posedge hclk);
		xfer(1'b0, 8'h00, 32'h0); chk({31'h0, rd !== a}, 32'h1, 32'h1);
		xfer(1'b1, 8'h08, 32'h0);
		xfer(1'b0, 8'h00, 32'h0);
		a = rd;
		repeat (40) @(posedge hclk);
		xfer(1'b0, 8'h00, 32'h0); chk(rd, a, a);
		// The pin reads back as a port level in timer mode.
		src_u.level(1'b1);
		repeat (4) @(posedge hclk);
		xfer(1'b0, 8'h0C, 32'h0); chk(rd, 32'h1, 32'h1);
		src_u.level(1'b0);
		repeat (4) @(posedge hclk);
		xfer(1'b0, 8'h0C, 32'h0); chk(rd, 32'h0, 32'h0);
		// Event counting: three pulses against rising, falling and both edge codes.
		for (int e = 0; e < 4; e++) begin
			xfer(1'b1, 8'h04, 32'(1 | (e << 4)));
			xfer(1'b1, 8'h00, 32'hA);
			xfer(1'b1, 8'h08, 32'h1);
			src_u.pulses(3, 4, 4);
			repeat (6) @(posedge hclk);
			xfer(1'b0, 8'h00, 32'h0);
			chk(rd, (e >= 2) ? 32'h4 : 32'h7, (e >= 2) ? 32'h4 : 32'h7);
			xfer(1'b1, 8'h08, 32'h0);
		end
		xfer(1'b1, 8'h04, 32'h41);
		xfer(1'b1, 8'h00, 32'hA);
		xfer(1'b1, 8'h08, 32'h1);
		opulse(3);
		repeat (4) @(posedge hclk);
		xfer(1'b0, 8'h00, 32'h0); chk(rd, 32'h7, 32'h7);
		// With the clock enable low, overflow pulses must not be counted.
		ce <= 1'b0;
		opulse(3);
		ce <= 1'b1;
		xfer(1'b0, 8'h00, 32'h0); chk(rd, 32'h7, 32'h7);
		// Period measurement: rising edges 40 cycles apart.
		xfer(1'b1, 8'h08, 32'h0);
		xfer(1'b1, 8'h04, 32'h2);
		xfer(1'b1, 8'h08, 32'h1);
		b = irqs;
		src_u.pulses(3, 10, 30);
		xfer(1'b0, 8'h00, 32'h0); chk(rd, 32'd39, 32'd40);
		chk(32'(irqs - b), 32'h2, 32'h2);
		xfer(1'b1, 8'h00, 32'h5);
		xfer(1'b0, 8'h00, 32'h0); chk(rd, 32'd39, 32'd40);
		// Width measurement: the last capture spans the 10-cycle high level.
		xfer(1'b1, 8'h08, 32'h0);
		xfer(1'b1, 8'h04, 32'h82);
		xfer(1'b1, 8'h08, 32'h1);
		b = irqs;
		src_u.pulses(2, 10, 30);
		xfer(1'b0, 8'h00, 32'h0); chk(rd, 32'd9, 32'd10);
		chk(32'(irqs - b), 32'h3, 32'h3);
		// No edges at all: the up count overflows once.
		xfer(1'b1, 8'h08, 32'h0);
		xfer(1'b1, 8'h04, 32'h2);
		xfer(1'b1, 8'h08, 32'h1);
		b = irqs;
		repeat (65600) @(posedge hclk);
		xfer(1'b0, 8'h04, 32'h0); chk({31'h0, rd[8]}, 32'h1, 32'h1);
		chk(32'(irqs - b), 32'h1, 32'h1);
		xfer(1'b1, 8'h04, 32'h2);
		xfer(1'b0, 8'h04, 32'h0); chk({31'h0, rd[8]}, 32'h0, 32'h0);
		test_done;
	end
	// The tests need some 69000 cycles; the overflow wait dominates.
	initial begin
		repeat (100000) @(posedge hclk);
		mismatches++;
		test_done;
	end
endmodule
`default_nettype wire
